// file: design/lsa_regs.vh
// Constants for the load/store alignment datapath.
// Assumes inclusion by the datapath modules only.
`ifndef LSA_REGS_VH
`define LSA_REGS_VH
`define LSA_OP_LDSB 4'h0
`define LSA_OP_LDUB 4'h1
`define LSA_OP_LDSH 4'h2
`define LSA_OP_LDUH 4'h3
`define LSA_OP_LD 4'h4
`define LSA_OP_LDD 4'h5
`define LSA_OP_LDX 4'h6
`define LSA_OP_STB 4'h8
`define LSA_OP_STH 4'h9
`define LSA_OP_ST 4'ha
`define LSA_OP_STD 4'hb
`define LSA_OP_STX 4'hc
`define LSA_SIZE_B 3'h0
`define LSA_SIZE_H 3'h1
`define LSA_SIZE_W 3'h2
`define LSA_SIZE_D 3'h3
`define LSA_SIZE_X 3'h4
`define LSA_FS_SIGN 31
`define LSA_FS_EXP_HI 30
`define LSA_FS_EXP_LO 23
`define LSA_FS_FRAC_HI 22
`define LSA_FD_EXP_LO 20
`define LSA_FX_EXP_LO 16
`define LSA_FX_RSV_HI 15
`endif

// file: design/lsa_align_chk.v
// Alignment checker for the load/store datapath.
// Assumes a size code from the main datapath.
`timescale 1ns/1ps
module lsa_align_chk
(
  input wire [2:0] size_i,
  input wire [3:0] addr_lo_i,
  output reg misalign_o
);
`include "lsa_regs.vh"
  always @*
  begin
    case (size_i)
      `LSA_SIZE_B: misalign_o = 1'b0;
      `LSA_SIZE_H: misalign_o = addr_lo_i[0]; // RULE15
      `LSA_SIZE_W: misalign_o = |addr_lo_i[1:0]; // RULE16
      `LSA_SIZE_D: misalign_o = |addr_lo_i[2:0]; // RULE16
      `LSA_SIZE_X: misalign_o = |addr_lo_i[3:0]; // RULE19
      default: misalign_o = 1'b0;
    endcase
  end
endmodule

// file: design/lsa_datapath.v
// Load/store data alignment and formatting datapath.
// Assumes a big-endian 32-bit memory data bus and a register file outside.
// What this block does
// RULE1: Byte operand uses register bits 7 to 0.
// RULE2: Byte load sign or zero extends bits 31:8.
// RULE3: Halfword operand uses register bits 15 to 0.
// RULE4: Halfword load sign or zero extends 31:16.
// RULE5: Words transfer all 32 bits unchanged.
// RULE6: Narrow stores write operand bits only, unextended.
// RULE7: Tagged data moves as an unsigned word.
// RULE8: Doubleword uses r[n] high, r[n+1] low.
// RULE9: Single float: sign 31, exponent 30:23, fraction.
// RULE10: Double float pair, 11-bit exponent, 52 fraction.
// RULE11: Wide load destination forced even.
// RULE12: Doubleword load to r0 drops high word.
// RULE13: Memory byte order is big-endian.
// RULE14: Operand address is its most significant byte.
// RULE15: Halfword aligned when address bit 0 zero.
// RULE16: Word needs bits 1:0, double 2:0 zero.
// RULE17: Misaligned access is blocked and traps.
// RULE18: Extended float uses four registers, fields fixed.
// RULE19: Extended operand needs 16-byte alignment.
// RULE20: Narrow store steered to big-endian byte lanes.
`timescale 1ns/1ps
module lsa_datapath
#(
  parameter RA_W = 5
)
(
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire req_i,
  input wire [3:0] op_i,
  input wire [31:0] addr_i,
  input wire [RA_W-1:0] rd_i,
  input wire [31:0] st_data_i,
  input wire [31:0] mem_rdata_i,
  output wire busy_o,
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [31:0] mem_addr_o,
  output reg [3:0] mem_be_o,
  output reg [31:0] mem_wdata_o,
  output reg [RA_W-1:0] st_ra_o,
  output reg rf_we_o,
  output reg [RA_W-1:0] rf_wa_o,
  output reg [31:0] rf_wdata_o,
  output reg trap_o,
  output reg done_o
);
`include "lsa_regs.vh"
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  reg [1:0] state_q;
  reg [3:0] op_q;
  reg [31:0] addr_q;
  reg [RA_W-1:0] rd_q;
  reg [1:0] beat_q;
  reg [1:0] last_q;
  reg is_st_q;
  reg is_ld_w_q;
  wire [2:0] size_w;
  wire misalign_w;
  wire [RA_W-1:0] rd_even_w;
  wire [1:0] nbeat_w;
  wire [RA_W-1:0] beat_ra_w;
  wire [31:0] beat_addr_w;

  function [2:0] op_size;
    input [3:0] op;
    begin
      case (op)
        `LSA_OP_LDSB, `LSA_OP_LDUB, `LSA_OP_STB: op_size = `LSA_SIZE_B;
        `LSA_OP_LDSH, `LSA_OP_LDUH, `LSA_OP_STH: op_size = `LSA_SIZE_H;
        `LSA_OP_LDD, `LSA_OP_STD: op_size = `LSA_SIZE_D;
        `LSA_OP_LDX, `LSA_OP_STX: op_size = `LSA_SIZE_X;
        default: op_size = `LSA_SIZE_W;
      endcase
    end
  endfunction

  function is_wide;
    input [3:0] op;
    begin
      is_wide = (op == `LSA_OP_LDD) || (op == `LSA_OP_LDX) ||
        (op == `LSA_OP_STD) || (op == `LSA_OP_STX);
    end
  endfunction

  // Selects the byte or halfword from the big-endian lanes and extends it.
  function [31:0] load_fmt;
    input [3:0] op;
    input [1:0] a;
    input [31:0] d;
    reg [7:0] b;
    reg [15:0] h;
    begin
      b = 8'h00;
      h = 16'h0000;
      case (a)
        2'h0: b = d[31:24]; // RULE13
        2'h1: b = d[23:16];
        2'h2: b = d[15:8];
        default: b = d[7:0];
      endcase
      h = a[1] ? d[15:0] : d[31:16]; // RULE14
      case (op)
        `LSA_OP_LDSB: load_fmt = {{24{b[7]}}, b}; // RULE1 RULE2
        `LSA_OP_LDUB: load_fmt = {24'h000000, b}; // RULE2
        `LSA_OP_LDSH: load_fmt = {{16{h[15]}}, h}; // RULE3 RULE4
        `LSA_OP_LDUH: load_fmt = {16'h0000, h}; // RULE4
        default: load_fmt = d; // RULE5 RULE7 RULE9
      endcase
    end
  endfunction

  // Rebuilds each floating-point beat from its fields except extended beat 2, which passes unchanged,
  // so each field keeps its fixed place in the register in both directions.
  function [31:0] fp_word;
    input [3:0] op;
    input [1:0] beat;
    input [31:0] d;
    reg sgn;
    reg [14:0] ex;
    reg [22:0] fr;
    reg [15:0] rsv;
    reg [31:0] w;
    begin
      sgn = d[`LSA_FS_SIGN];
      ex = 15'h0000;
      fr = 23'h000000;
      rsv = 16'h0000;
      w = d;
      case (op)
        `LSA_OP_LD, `LSA_OP_ST:
        begin
          ex[7:0] = d[`LSA_FS_EXP_HI:`LSA_FS_EXP_LO];
          fr = d[`LSA_FS_FRAC_HI:0];
          w = {sgn, ex[7:0], fr}; // RULE9
        end
        `LSA_OP_LDD, `LSA_OP_STD:
        begin
          case (beat)
            2'h0:
            begin
              ex[10:0] = d[`LSA_FS_EXP_HI:`LSA_FD_EXP_LO];
              fr[19:0] = d[`LSA_FD_EXP_LO-1:0];
              w = {sgn, ex[10:0], fr[19:0]}; // RULE10
            end
            default:
            begin
              fr = d[`LSA_FS_FRAC_HI:0];
              w = {d[31:23], fr}; // RULE10
            end
          endcase
        end
        `LSA_OP_LDX, `LSA_OP_STX:
        begin
          case (beat)
            2'h0:
            begin
              ex = d[`LSA_FS_EXP_HI:`LSA_FX_EXP_LO];
              rsv = d[`LSA_FX_RSV_HI:0];
              w = {sgn, ex, rsv}; // RULE18
            end
            2'h1:
            begin
              fr = d[`LSA_FS_FRAC_HI:0];
              w = {sgn, d[30:23], fr}; // RULE18
            end
            default:
            begin
              w = d; // RULE18
            end
          endcase
        end
        default:
        begin
          w = d;
        end
      endcase
      fp_word = w;
    end
  endfunction

  // Byte enable of a store beat; bit 3 is the lane at the lowest address.
  function [3:0] narrow_be;
    input [3:0] op;
    input [1:0] a;
    begin
      case (op)
        `LSA_OP_STB:
        begin
          case (a)
            2'h0: narrow_be = 4'h8; // RULE20
            2'h1: narrow_be = 4'h4;
            2'h2: narrow_be = 4'h2;
            default: narrow_be = 4'h1;
          endcase
        end
        `LSA_OP_STH: narrow_be = a[1] ? 4'h3 : 4'hc; // RULE20
        default: narrow_be = 4'hf; // RULE5 RULE7
      endcase
    end
  endfunction

  // Store data of a beat: narrow operands go out unextended on every lane.
  function [31:0] store_word;
    input [3:0] op;
    input [1:0] beat;
    input [31:0] d;
    begin
      case (op)
        `LSA_OP_STB: store_word = {4{d[7:0]}}; // RULE1 RULE6
        `LSA_OP_STH: store_word = {2{d[15:0]}}; // RULE3 RULE6
        default: store_word = fp_word(op, beat, d); // RULE5
      endcase
    end
  endfunction

  lsa_align_chk u_align
  (
    .size_i(size_w),
    .addr_lo_i(addr_i[3:0]),
    .misalign_o(misalign_w)
  );

  assign size_w = op_size(op_i);
  assign rd_even_w = is_wide(op_i) ? {rd_i[RA_W-1:1], 1'b0} : rd_i; // RULE11
  // Extended operands use three data words; the fourth register is reserved.
  assign nbeat_w = (size_w == `LSA_SIZE_X) ? 2'h2 :
    ((size_w == `LSA_SIZE_D) ? 2'h1 : 2'h0); // RULE8 RULE10 RULE18
  assign beat_ra_w = rd_q + {{(RA_W-2){1'b0}}, beat_q}; // RULE8
  assign beat_addr_w = {addr_q[31:4], addr_q[3:2] + beat_q, addr_q[1:0]};
  assign busy_o = (state_q != ST_IDLE);

  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      op_q <= 4'h0;
      addr_q <= 32'h00000000;
      rd_q <= {RA_W{1'b0}};
      beat_q <= 2'h0;
      last_q <= 2'h0;
      is_st_q <= 1'b0;
      is_ld_w_q <= 1'b0;
      trap_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      trap_o <= 1'b0;
      done_o <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (req_i && misalign_w)
          begin
            trap_o <= 1'b1; // RULE17
            done_o <= 1'b1;
          end
          else if (req_i)
          begin
            state_q <= ST_RUN;
            op_q <= op_i;
            addr_q <= addr_i;
            rd_q <= rd_even_w;
            beat_q <= 2'h0;
            last_q <= nbeat_w;
            is_st_q <= op_i[3];
            is_ld_w_q <= is_wide(op_i) && !op_i[3];
          end
        end
        ST_RUN:
        begin
          if (beat_q == last_q)
          begin
            state_q <= ST_IDLE;
            done_o <= 1'b1;
          end
          else
          begin
            beat_q <= beat_q + 2'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Memory side: one word per cycle; read data returns in the same cycle.
  always @*
  begin
    mem_req_o = (state_q == ST_RUN);
    mem_we_o = (state_q == ST_RUN) && is_st_q;
    mem_addr_o = beat_addr_w; // RULE14
    st_ra_o = beat_ra_w;
    mem_be_o = narrow_be(op_q, addr_q[1:0]);
    mem_wdata_o = store_word(op_q, beat_q, st_data_i);
  end

  always @*
  begin
    rf_we_o = (state_q == ST_RUN) && !is_st_q;
    rf_wa_o = beat_ra_w;
    rf_wdata_o = fp_word(op_q, beat_q,
      load_fmt(op_q, addr_q[1:0], mem_rdata_i));
    if (is_ld_w_q && (beat_ra_w == {RA_W{1'b0}}))
    begin
      rf_we_o = 1'b0; // RULE12
    end
  end
endmodule

// file: verif/lsa_monitor.sv
// Checker for the load/store alignment datapath.
// Assumes one clock and the opcode codes of the design header.
`timescale 1ns/1ps
module lsa_monitor #(parameter RA_W = 5)
(
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire req_i,
  input wire [3:0] op_i,
  input wire [31:0] addr_i,
  input wire [RA_W-1:0] rd_i,
  input wire busy_o,
  input wire mem_req_o,
  input wire [3:0] mem_be_o,
  input wire rf_we_o,
  input wire [RA_W-1:0] rf_wa_o,
  input wire trap_o,
  input wire done_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire go = req_i && !busy_o;
  a_trap_no_beat:
    assert property (trap_o |-> !mem_req_o && !rf_we_o) else $error("beat");
  a_half_odd:
    assert property (go && op_i == 4'h2 && addr_i[0] |=> trap_o)
    else $error("half");
  a_word_odd:
    assert property (go && op_i == 4'h4 && addr_i[1:0] != 0 |=> trap_o)
    else $error("word");
  a_dbl_odd:
    assert property (go && op_i == 4'h5 && addr_i[2:0] != 0 |=> trap_o)
    else $error("dbl");
  a_ext_odd:
    assert property (go && op_i == 4'h6 && addr_i[3:0] != 0 |=> trap_o)
    else $error("ext");
  a_word_ok:
    assert property (go && op_i == 4'h4 && addr_i[1:0] == 0
      |=> !trap_o && mem_req_o ##1 done_o) else $error("word ok");
  a_dbl_pair:
    assert property (go && op_i == 4'h5 && addr_i[2:0] == 0 && rd_i > 1
      |=> rf_we_o && !rf_wa_o[0] ##1 rf_we_o && rf_wa_o[0])
    else $error("pair");
  a_dbl_zero:
    assert property (go && op_i == 4'h5 && addr_i[2:0] == 0 && rd_i == 0
      |=> !rf_we_o ##1 rf_we_o && rf_wa_o == 1) else $error("r0");
  a_byte_lane:
    assert property (go && op_i == 4'h8
      |=> mem_be_o == (4'h8 >> $past(addr_i[1:0]))) else $error("lane");
  c_trap: cover property (trap_o);
  c_done: cover property (done_o && !trap_o);
  c_beat: cover property (mem_req_o ##1 mem_req_o);
endmodule
bind lsa_datapath lsa_monitor #(.RA_W(RA_W)) mon (.clk_sys_i, .rst_n_i,
  .req_i, .op_i, .addr_i, .rd_i, .busy_o, .mem_req_o, .mem_be_o, .rf_we_o,
  .rf_wa_o, .trap_o, .done_o);

// file: verif/lsa_mem_model.sv
// Memory and register file model for the alignment datapath.
// Assumes single-cycle beats and combinational read data.
`timescale 1ns/1ps
module lsa_mem_model
(
  input wire clk_sys_i,
  input wire mem_req_i,
  input wire mem_we_i,
  input wire [31:0] mem_addr_i,
  input wire [3:0] mem_be_i,
  input wire [31:0] mem_wdata_i,
  input wire [4:0] st_ra_i,
  input wire rf_we_i,
  input wire [4:0] rf_wa_i,
  input wire [31:0] rf_wdata_i,
  output wire [31:0] mem_rdata_o,
  output wire [31:0] st_data_o
);
  reg [31:0] mem [0:15];
  reg [31:0] rf [0:31];
  wire [31:0] wd = mem[mem_addr_i[5:2]];
  integer i;
  integer k;
  initial for (k = 0; k < 32; k = k + 1) rf[k] = 32'h0;
  // Outside a beat the bus shows the inverse, never a held value.
  assign mem_rdata_o = mem_req_i ? wd : ~wd;
  assign st_data_o = rf[st_ra_i];
  always @(posedge clk_sys_i)
  begin
    for (i = 0; i < 4; i = i + 1)
      if (mem_req_i && mem_we_i && mem_be_i[i])
        mem[mem_addr_i[5:2]][8*i +: 8] <= mem_wdata_i[8*i +: 8];
    if (rf_we_i)
      rf[rf_wa_i] <= rf_wdata_i;
  end
endmodule

// file: verif/load_store_data_alignment_bench.sv
// Self-checking bench for the load/store alignment datapath.
// Assumes the memory and register model beside the design.
`timescale 1ns/1ps
module load_store_data_alignment_bench;
  reg clk_sys_i = 0;
  reg rst_n_i = 0;
  reg req = 0;
  reg [3:0] op = 4'h0;
  reg [31:0] ad = 32'h0;
  reg [4:0] rd = 5'h0;
  reg tr;
  integer mismatches = 0;
  integer n_tests = 0;
  integer cyc = 0;
  wire bsy, mq, mw, rw, trp, dn;
  wire [3:0] be;
  wire [4:0] sa, wa;
  wire [31:0] ma, md, rdt, sd, rwd;
  lsa_datapath uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req),
    .op_i(op), .addr_i(ad), .rd_i(rd), .st_data_i(sd), .mem_rdata_i(rdt),
    .busy_o(bsy), .mem_req_o(mq), .mem_we_o(mw), .mem_addr_o(ma),
    .mem_be_o(be), .mem_wdata_o(md), .st_ra_o(sa), .rf_we_o(rw),
    .rf_wa_o(wa), .rf_wdata_o(rwd), .trap_o(trp), .done_o(dn));
  lsa_mem_model m (.clk_sys_i(clk_sys_i), .mem_req_i(mq), .mem_we_i(mw),
    .mem_addr_i(ma), .mem_be_i(be), .mem_wdata_i(md), .st_ra_i(sa),
    .rf_we_i(rw), .rf_wa_i(wa), .rf_wdata_i(rwd), .mem_rdata_o(rdt),
    .st_data_o(sd));
  task final_report;
  begin
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task run(input [3:0] o, input [31:0] a, input [4:0] r);
    integer n;
  begin
    @(negedge clk_sys_i);
    req = 1;
    op = o;
    ad = a;
    rd = r;
    @(negedge clk_sys_i);
    req = 0;
    n = 0;
    while (dn !== 1'b1 && n < 9)
    begin
      @(negedge clk_sys_i);
      n = n + 1;
    end
    tr = trp;
  end
  endtask
  task tp(input [3:0] o, input [31:0] a);
  begin
    run(o, a, 5'h6);
    chk("trap", 32'h1, {31'h0, tr});
  end
  endtask
  task t_load;
  begin
    run(4'h0, 32'h1, 5'h3);
    chk("ldsb", 32'hfffffff2, m.rf[3]);
    run(4'h1, 32'h2, 5'h3);
    chk("ldub", 32'h73, m.rf[3]);
    run(4'h2, 32'h0, 5'h4);
    chk("ldsh", 32'hffff81f2, m.rf[4]);
    run(4'h3, 32'h2, 5'h4);
    chk("lduh", 32'h7384, m.rf[4]);
    run(4'h4, 32'h4, 5'h5);
    chk("ld", 32'h55667788, m.rf[5]);
  end
  endtask
  task t_wide;
  begin
    run(4'h5, 32'h8, 5'h9);
    chk("ldd hi", 32'h99aabbcc, m.rf[8]);
    chk("ldd lo", 32'h0f1e2d3c, m.rf[9]);
    run(4'h5, 32'h0, 5'h0);
    chk("r0", 32'h0, m.rf[0]);
    chk("r1", 32'h55667788, m.rf[1]);
    run(4'h6, 32'h0, 5'hd);
    chk("x0", 32'h81f27384, m.rf[12]);
    chk("x2", 32'h99aabbcc, m.rf[14]);
    chk("x3", 32'h0, m.rf[15]);
  end
  endtask
  task t_trap;
  begin
    tp(4'h2, 32'h1);
    tp(4'h4, 32'h2);
    tp(4'h5, 32'h4);
    tp(4'h6, 32'h8);
    tp(4'h9, 32'h3);
    tp(4'hb, 32'hc);
    tp(4'hc, 32'h4);
    chk("rf6", 32'h0, m.rf[6]);
    chk("mem0", 32'h81f27384, m.mem[0]);
    chk("mem3", 32'h0f1e2d3c, m.mem[3]);
  end
  endtask
  task t_store;
  begin
    run(4'h8, 32'h6, 5'h14);
    chk("stb", 32'h5566a588, m.mem[1]);
    run(4'h9, 32'ha, 5'h14);
    chk("sth", 32'h99aaf0a5, m.mem[2]);
    run(4'hb, 32'h10, 5'h15);
    chk("std", 32'hcafef0a5, m.mem[4]);
    chk("std lo", 32'h01234567, m.mem[5]);
    run(4'ha, 32'h18, 5'h15);
    chk("st", 32'h01234567, m.mem[6]);
  end
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      mismatches = mismatches + 1;
      final_report;
    end
  end
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  initial
  begin
    repeat (6) @(negedge clk_sys_i);
    m.mem[0] = 32'h81f27384;
    m.mem[1] = 32'h55667788;
    m.mem[2] = 32'h99aabbcc;
    m.mem[3] = 32'h0f1e2d3c;
    m.rf[20] = 32'hcafef0a5;
    m.rf[21] = 32'h01234567;
    rst_n_i = 1;
    t_load;
    t_wide;
    t_trap;
    t_store;
    final_report;
  end
endmodule
